// ==== common/rac_pkg.sv ====
// shared constants and carrier types of the alarm compare unit
package rac_pkg;

    // ***********************************************************
    // register map
    // ***********************************************************
    localparam logic [7:0] TIME_FIRST_ADDR = 8'h00;
    localparam logic [7:0] TIME_LAST_ADDR = 8'h07;
    localparam logic [7:0] ALARM1_SECONDS_ADDR = 8'h08;
    localparam logic [7:0] ALARM1_MINUTES_ADDR = 8'h09;
    localparam logic [7:0] ALARM1_HOURS_ADDR = 8'h0A;
    localparam logic [7:0] ALARM1_DAY_OF_MONTH_ADDR = 8'h0B;
    localparam logic [7:0] ALARM1_MONTH_ADDR = 8'h0C;
    localparam logic [7:0] ALARM2_MINUTES_ADDR = 8'h0D;
    localparam logic [7:0] ALARM2_HOURS_ADDR = 8'h0E;
    localparam logic [7:0] ALARM2_DAY_OF_WEEK_ADDR = 8'h0F;
    localparam logic [7:0] ALARM_FIELD_ENABLES_ADDR = 8'h10;
    localparam logic [7:0] ALARM_FIELD_ENABLES_RST = 8'h00;
    localparam logic [7:0] ALARM_REG_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ***********************************************************
    // enable bit positions
    // ***********************************************************
    localparam int ALM1_SECOND_EN = 0;
    localparam int ALM1_MINUTE_EN = 1;
    localparam int ALM1_HOUR_EN = 2;
    localparam int ALM1_DAY_EN = 3;
    localparam int ALM1_MONTH_EN = 4;
    localparam int ALM2_MINUTE_EN = 5;
    localparam int ALM2_HOUR_EN = 6;
    localparam int ALM2_WEEKDAY_EN = 7;

    // ***********************************************************
    // time counter locations
    // ***********************************************************
    localparam logic [2:0] TIME_SECONDS = 3'h1;
    localparam logic [2:0] TIME_MINUTES = 3'h2;
    localparam logic [2:0] TIME_HOURS = 3'h3;
    localparam logic [2:0] TIME_DAY = 3'h4;
    localparam logic [2:0] TIME_HOURS_MID = 3'h4;
    localparam logic [2:0] TIME_WEEKDAY = 3'h5;
    localparam logic [2:0] TIME_HOURS_TOP = 3'h5;
    localparam logic [2:0] TIME_MONTH = 3'h6;

    // ***********************************************************
    // implemented bits per field
    // ***********************************************************
    localparam logic [7:0] MASK_SEC_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_BCD_PAIR = 8'hFF;

    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CNT_W = 8;

    // ***********************************************************
    // carriers
    // ***********************************************************
    typedef struct packed {
        logic [7:0][7:0] loc;
    } rac_time_s;

    typedef struct packed {
        logic alarm1_to_a;
        logic alarm1_to_b;
        logic alarm2_to_a;
        logic alarm2_to_b;
        logic pulse_mode_a;
        logic pulse_mode_b;
    } rac_irq_cfg_s;

endpackage

// ==== core/rac_field_match.sv ====
// all-enabled-fields comparator for one alarm
`timescale 1ns/1ps
`default_nettype none

module rac_field_match #(
    parameter int NUM_FIELDS = 3
) (
    // fields
    input wire logic [NUM_FIELDS-1:0][7:0] alarm_i,
    input wire logic [NUM_FIELDS-1:0][7:0] now_i,
    input wire logic [NUM_FIELDS-1:0][7:0] mask_i,
    input wire logic [NUM_FIELDS-1:0] enable_i,
    // result
    output logic match_o
);

    logic [NUM_FIELDS-1:0] field_ok;

    // a disabled field always agrees, so it drops out of the condition
    for (genvar i = 0; i < NUM_FIELDS; i++)
    begin : g_field
        assign field_ok[i] = !enable_i[i] || ((alarm_i[i] & mask_i[i]) == (now_i[i] & mask_i[i]));
    end

    // an alarm with nothing enabled never fires
    assign match_o = (|enable_i) && (&field_ok);

endmodule
`default_nettype wire

// ==== core/rac_alarm_unit.sv ====
// alarm compare unit with read snapshot of the time counters
`timescale 1ns/1ps
`default_nettype none

// How it works
// - a host transfer start copies time locations 00h-07h into a read snapshot
// - the counters outside keep running; the snapshot never stalls them
// - two alarms, each with its own fields, flag and interrupt routing
// - calendar mode compares time and date, elapsed mode compares time only
// - alarm one compares seconds, minutes, hours, day, month, each enabled separately
// - alarm two compares minutes, hours, weekday, each enabled separately
// - alarm one values sit at 08h-0Ch: seconds, minutes, hours, day, month
// - alarm two values sit at 0Dh-0Fh: minutes, hours, weekday
// - enable register 10h bit map as listed; resets to zero
// - each enabled field is compared with the matching current field
// - disabled fields take no part in the match
// - time stepping into a full match sets that alarm's flag
// - flag stays until the host clears it by command
// - each alarm can drive either or both active-low interrupt pins
// - elapsed mode: alarm one to six-digit hours, alarm two to four-digit hours
// - unimplemented alarm bits hold no state and read as zero
// - mode bit one selects elapsed counting, zero selects calendar
// - interrupt pins give a pulse per new match or follow the flag
// - after clearing, a flag sets again only on the next new match
module rac_alarm_unit (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // time base
    input wire logic tick_i,
    input wire rac_pkg::rac_time_s time_i,
    input wire logic elapsed_mode_select_i,
    // register port from the serial host interface
    input wire logic xfer_start_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // flag commands and interrupt control
    input wire logic clr_first_alarm_flag_i,
    input wire logic clr_second_alarm_flag_i,
    input wire rac_pkg::rac_irq_cfg_s irq_cfg_i,
    // status and pins
    output logic first_alarm_flag_o,
    output logic second_alarm_flag_o,
    output logic irq_out_a_n_o,
    output logic irq_out_b_n_o
);

    // ***********************************************************
    // storage
    // ***********************************************************
    rac_pkg::rac_time_s snap;
    logic [7:0][7:0] alarm_reg;
    logic [7:0] field_en;
    logic [7:0][7:0] keep_mask;
    logic [2:0] alarm_idx;
    logic alarm_hit;
    logic mode_d;

    // implemented bits of each alarm location for the current mode
    always_comb
    begin
        if (elapsed_mode_select_i)
        begin
            keep_mask = {rac_pkg::MASK_BCD_PAIR, rac_pkg::MASK_BCD_PAIR,
                         rac_pkg::MASK_SEC_MIN, rac_pkg::MASK_BCD_PAIR,
                         rac_pkg::MASK_BCD_PAIR, rac_pkg::MASK_BCD_PAIR,
                         rac_pkg::MASK_SEC_MIN, rac_pkg::MASK_SEC_MIN};
        end
        else
        begin
            keep_mask = {rac_pkg::MASK_WEEKDAY, rac_pkg::MASK_HOUR,
                         rac_pkg::MASK_SEC_MIN, rac_pkg::MASK_MONTH,
                         rac_pkg::MASK_DAY, rac_pkg::MASK_HOUR,
                         rac_pkg::MASK_SEC_MIN, rac_pkg::MASK_SEC_MIN};
        end
    end

    assign alarm_idx = reg_addr_i[2:0];
    assign alarm_hit = (reg_addr_i >= rac_pkg::ALARM1_SECONDS_ADDR)
                    && (reg_addr_i <= rac_pkg::ALARM2_DAY_OF_WEEK_ADDR);

    // snapshot taken once per transfer; the counters are never held
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            snap <= '0;
        else if (xfer_start_i)
            snap <= time_i;
    end

    // alarm values; bits outside the mode's mask are dropped on write and on a mode switch
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            alarm_reg <= {8{rac_pkg::ALARM_REG_RST}};
            mode_d <= 1'b0;
        end
        else
        begin
            mode_d <= elapsed_mode_select_i;
            // a switch to calendar narrows the fields, so stale upper bits must not survive
            if (elapsed_mode_select_i != mode_d)
                alarm_reg <= alarm_reg & keep_mask;
            if (reg_wr_i && alarm_hit)
                alarm_reg[alarm_idx] <= reg_wdata_i & keep_mask[alarm_idx];
        end
    end

    // field enables
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            field_en <= rac_pkg::ALARM_FIELD_ENABLES_RST;
        else if (reg_wr_i && reg_addr_i == rac_pkg::ALARM_FIELD_ENABLES_ADDR)
            field_en <= reg_wdata_i;
    end

    // ***********************************************************
    // register read
    // ***********************************************************
    // time locations return the snapshot so a multi-byte read is coherent
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            reg_rdata_o <= rac_pkg::UNMAPPED_READ;
        else if (reg_rd_i)
        begin
            if (reg_addr_i <= rac_pkg::TIME_LAST_ADDR)
                reg_rdata_o <= snap.loc[reg_addr_i[2:0]];
            else if (alarm_hit)
                reg_rdata_o <= alarm_reg[alarm_idx] & keep_mask[alarm_idx];
            else if (reg_addr_i == rac_pkg::ALARM_FIELD_ENABLES_ADDR)
                reg_rdata_o <= field_en;
            else
                reg_rdata_o <= rac_pkg::UNMAPPED_READ;
        end
    end

    // ***********************************************************
    // field selection and compare
    // ***********************************************************
    logic [4:0][7:0] now1;
    logic [4:0][7:0] msk1;
    logic [2:0][7:0] now2;
    logic [2:0][7:0] msk2;
    logic match1;
    logic match2;

    // route the live counters onto the alarm fields for the mode
    always_comb
    begin
        now1[0] = time_i.loc[rac_pkg::TIME_SECONDS];
        now1[1] = time_i.loc[rac_pkg::TIME_MINUTES];
        now1[2] = time_i.loc[rac_pkg::TIME_HOURS];
        now2[0] = time_i.loc[rac_pkg::TIME_MINUTES];
        now2[1] = time_i.loc[rac_pkg::TIME_HOURS];
        if (elapsed_mode_select_i)
        begin
            now1[3] = time_i.loc[rac_pkg::TIME_HOURS_MID];
            now1[4] = time_i.loc[rac_pkg::TIME_HOURS_TOP];
            now2[2] = time_i.loc[rac_pkg::TIME_HOURS_MID];
        end
        else
        begin
            now1[3] = time_i.loc[rac_pkg::TIME_DAY];
            now1[4] = time_i.loc[rac_pkg::TIME_MONTH];
            now2[2] = time_i.loc[rac_pkg::TIME_WEEKDAY];
        end
        msk1 = keep_mask[4:0];
        msk2 = keep_mask[7:5];
    end

    // one comparator per alarm, each with its own enables
    rac_field_match #(
        .NUM_FIELDS(5)
    ) u_match1 (
        .alarm_i(alarm_reg[4:0]),
        .now_i(now1),
        .mask_i(msk1),
        .enable_i(field_en[rac_pkg::ALM1_MONTH_EN:rac_pkg::ALM1_SECOND_EN]),
        .match_o(match1)
    );

    rac_field_match #(
        .NUM_FIELDS(3)
    ) u_match2 (
        .alarm_i(alarm_reg[7:5]),
        .now_i(now2),
        .mask_i(msk2),
        .enable_i(field_en[rac_pkg::ALM2_WEEKDAY_EN:rac_pkg::ALM2_MINUTE_EN]),
        .match_o(match2)
    );

    // ***********************************************************
    // match events and flags
    // ***********************************************************
    logic tick_d;
    logic match1_prev;
    logic match2_prev;
    logic event1;
    logic event2;

    // counters settle one cycle after the tick; only a fresh match counts
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tick_d <= 1'b0;
            match1_prev <= 1'b0;
            match2_prev <= 1'b0;
        end
        else
        begin
            tick_d <= tick_i;
            if (tick_d)
            begin
                match1_prev <= match1;
                match2_prev <= match2;
            end
        end
    end

    assign event1 = tick_d && match1 && !match1_prev;
    assign event2 = tick_d && match2 && !match2_prev;

    // a match in the clearing cycle wins over the clear
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            first_alarm_flag_o <= 1'b0;
            second_alarm_flag_o <= 1'b0;
        end
        else
        begin
            if (event1)
                first_alarm_flag_o <= 1'b1;
            else if (clr_first_alarm_flag_i)
                first_alarm_flag_o <= 1'b0;
            if (event2)
                second_alarm_flag_o <= 1'b1;
            else if (clr_second_alarm_flag_i)
                second_alarm_flag_o <= 1'b0;
        end
    end

    // ***********************************************************
    // interrupt pins
    // ***********************************************************
    logic [1:0] pin_event;
    logic [1:0] pin_level;
    logic [1:0] pin_pulse_mode;
    logic [1:0][rac_pkg::PULSE_CNT_W-1:0] pulse_cnt;
    logic [1:0] pin_active;

    assign pin_event[0] = (event1 && irq_cfg_i.alarm1_to_a) || (event2 && irq_cfg_i.alarm2_to_a);
    assign pin_event[1] = (event1 && irq_cfg_i.alarm1_to_b) || (event2 && irq_cfg_i.alarm2_to_b);
    assign pin_level[0] = (first_alarm_flag_o && irq_cfg_i.alarm1_to_a)
                       || (second_alarm_flag_o && irq_cfg_i.alarm2_to_a);
    assign pin_level[1] = (first_alarm_flag_o && irq_cfg_i.alarm1_to_b)
                       || (second_alarm_flag_o && irq_cfg_i.alarm2_to_b);
    assign pin_pulse_mode = {irq_cfg_i.pulse_mode_b, irq_cfg_i.pulse_mode_a};

    // a one-cycle 8 ns strobe would be lost on a board, so pulses are stretched to 1000 ns
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        always_ff @(posedge clock_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                pulse_cnt[p] <= '0;
            else if (pin_event[p])
                pulse_cnt[p] <= rac_pkg::PULSE_CNT_W'(rac_pkg::IRQ_PULSE_CYCLES);
            else if (pulse_cnt[p] != '0)
                pulse_cnt[p] <= pulse_cnt[p] - 1'b1;
        end
        assign pin_active[p] = pin_pulse_mode[p] ? (pulse_cnt[p] != '0) : pin_level[p];
    end

    // pins are registered so they never glitch
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_out_a_n_o <= 1'b1;
            irq_out_b_n_o <= 1'b1;
        end
        else
        begin
            irq_out_a_n_o <= !pin_active[0];
            irq_out_b_n_o <= !pin_active[1];
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    chk_snap_capture: assert property (xfer_start_i |=> snap == $past(time_i))
        else $error("snapshot differs from counters at transfer start");
    chk_snap_read: assert property (reg_rd_i && reg_addr_i <= rac_pkg::TIME_LAST_ADDR
        && !xfer_start_i |=> reg_rdata_o == snap.loc[$past(reg_addr_i[2:0])])
        else $error("time read did not return snapshot");
    chk_enable_read: assert property (reg_wr_i && reg_addr_i == rac_pkg::ALARM_FIELD_ENABLES_ADDR
        ##1 !reg_wr_i
        ##1 reg_rd_i && reg_addr_i == rac_pkg::ALARM_FIELD_ENABLES_ADDR && !reg_wr_i
        |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("enable register readback wrong");
    chk_weekday_bits: assert property (!elapsed_mode_select_i
        |-> alarm_reg[7][7:3] == 5'h00 || $past(elapsed_mode_select_i))
        else $error("unimplemented weekday bits hold state");
    chk_disabled_quiet: assert property (field_en[4:0] == 5'h00 |-> !match1)
        else $error("alarm one matched with all fields off");
    chk_flag_set: assert property (event1 |=> first_alarm_flag_o)
        else $error("alarm one flag not set on match");
    chk_flag_hold: assert property (second_alarm_flag_o && !clr_second_alarm_flag_i
        |=> second_alarm_flag_o)
        else $error("alarm two flag dropped without clear");
    chk_rearm_only: assert property (!first_alarm_flag_o && !event1 |=> !first_alarm_flag_o)
        else $error("alarm one flag set without new match");
    chk_level_pin: assert property (!irq_cfg_i.pulse_mode_a && $stable(irq_cfg_i)
        |=> irq_out_a_n_o == !$past(pin_level[0]))
        else $error("pin a does not follow flags in level mode");
    chk_pulse_width: assert property (pin_event[1] && irq_cfg_i.pulse_mode_b
        ##1 $stable(irq_cfg_i.pulse_mode_b) [*8] |-> !irq_out_b_n_o)
        else $error("pin b pulse too short");

    cov_alarm1: cover property (event1 ##1 first_alarm_flag_o);
    cov_alarm2_cleared: cover property (second_alarm_flag_o ##1 clr_second_alarm_flag_i);
    cov_pulse_a: cover property (irq_cfg_i.pulse_mode_a && $fell(irq_out_a_n_o));
    cov_snap_read: cover property (xfer_start_i ##1 reg_rd_i && reg_addr_i == 8'h03);

endmodule
`default_nettype wire

// ==== bench/rac_host_model.sv ====
// host and time-base model driving the register port and the time counters
`timescale 1ns/1ps
`default_nettype none

module rac_host_model (
    // clock
    input wire logic clock_i,
    // register port towards the unit
    output logic xfer_start_o,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    // flag clear commands
    output logic clr_first_o,
    output logic clr_second_o,
    // time base
    output logic tick_o,
    output var rac_pkg::rac_time_s time_o
);
    // idle levels at time zero
    initial
    begin
        {xfer_start_o, reg_wr_o, reg_rd_o, clr_first_o, clr_second_o, tick_o} = 6'h00;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        time_o = '0;
    end

    // released address and data flip to the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clock_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    // read data stands until the next read, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clock_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        @(posedge clock_i);
        #1;
        d = reg_rdata_i;
    endtask

    // one transfer start before the whole time is read
    task automatic snap();
        @(posedge clock_i);
        #1;
        xfer_start_o = 1'b1;
        @(posedge clock_i);
        #1;
        xfer_start_o = 1'b0;
    endtask

    // explicit flag clear command
    task automatic clr(input logic [1:0] w);
        @(posedge clock_i);
        #1;
        clr_first_o = w[0];
        clr_second_o = w[1];
        @(posedge clock_i);
        #1;
        {clr_first_o, clr_second_o} = 2'h0;
    endtask

    // counters advance with the tick; time is valid together with it
    task automatic step(input rac_pkg::rac_time_s t);
        @(posedge clock_i);
        #1;
        time_o = t;
        tick_o = 1'b1;
        @(posedge clock_i);
        #1;
        tick_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== bench/rac_alarm_unit_bench.sv ====
// self-checking testbench of the alarm compare unit
`timescale 1ns/1ps
`default_nettype none

module rac_alarm_unit_bench;
    logic clock;
    logic arst_n;
    logic mode;
    rac_pkg::rac_irq_cfg_s irq_cfg;
    logic xfer, wr, rd, clr1, clr2, tick;
    logic [7:0] addr, wdata, rdata;
    rac_pkg::rac_time_s tnow, ta;
    logic flag1, flag2, irq_a_n, irq_b_n;
    logic [7:0] d, a, w;
    int n;
    int err_count = 0;
    int comparisons = 0;

    // ****************************************
    // clock, instances
    // ****************************************
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    rac_host_model i_rac_host_model (
        .clock_i(clock), .xfer_start_o(xfer), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata), .clr_first_o(clr1),
        .clr_second_o(clr2), .tick_o(tick), .time_o(tnow)
    );

    rac_alarm_unit i_rac_alarm_unit (
        .clock_i(clock), .arst_n_i(arst_n), .tick_i(tick), .time_i(tnow),
        .elapsed_mode_select_i(mode), .xfer_start_i(xfer), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .clr_first_alarm_flag_i(clr1), .clr_second_alarm_flag_i(clr2),
        .irq_cfg_i(irq_cfg), .first_alarm_flag_o(flag1), .second_alarm_flag_o(flag2),
        .irq_out_a_n_o(irq_a_n), .irq_out_b_n_o(irq_b_n)
    );

    // ****************************************
    // helpers
    // ****************************************
    // implemented bits per location; elapsed hours keep both digits
    function automatic logic [7:0] reg_mask(input logic [7:0] ad, input logic em);
        case (ad)
            8'h08, 8'h09, 8'h0D: reg_mask = 8'h7F;
            8'h0A, 8'h0B, 8'h0E: reg_mask = em ? 8'hFF : 8'h3F;
            8'h0C: reg_mask = em ? 8'hFF : 8'h1F;
            8'h0F: reg_mask = em ? 8'hFF : 8'h07;
            8'h10: reg_mask = 8'hFF;
            default: reg_mask = 8'h00;
        endcase
    endfunction

    function automatic rac_pkg::rac_time_s mk(input logic [7:0] s, input logic [7:0] m,
                                              input logic [7:0] w);
        mk = '0;
        mk.loc[1] = s;
        mk.loc[2] = m;
        mk.loc[5] = w;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask

    task automatic cfg(input logic m, input logic [5:0] c);
        @(posedge clock);
        #1;
        mode = m;
        irq_cfg = c;
    endtask

    // flag lands one edge after the tick is taken
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests take
    initial
    begin
        #160000;
        err_count++;
        stop_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        arst_n = 1'b0;
        mode = 1'b0;
        irq_cfg = 6'h00;
        void'($urandom(32'h12DA));
        repeat (5) @(posedge clock);
        #1;
        arst_n = 1'b1;
        for (int i = 8; i <= 17; i++)
        begin
            i_rac_host_model.rd(8'(i), d);
            chk(d, 8'h00);
        end
        $display("test reset_values done");
        for (int i = 0; i < 24; i++)
        begin
            a = 8'h08 + 8'($urandom % 10);
            w = 8'($urandom);
            cfg(1'($urandom), 6'h00);
            i_rac_host_model.wr(a, w);
            i_rac_host_model.rd(a, d);
            chk(d, w & reg_mask(a, mode));
        end
        for (int i = 0; i < 2; i++)
        begin
            cfg(1'(i), 6'h00);
            i_rac_host_model.wr(8'h0C, 8'h99);
            i_rac_host_model.rd(8'h0C, d);
            chk(d, (i == 1) ? 8'h99 : 8'h19);
        end
        // random enables must not leak matches into the later tests
        i_rac_host_model.wr(8'h10, 8'h00);
        $display("test register_map done");
        cfg(1'b0, 6'h20);
        ta = mk(8'h45, 8'h59, 8'h06);
        ta.loc[0] = 8'h37;
        ta.loc[3] = 8'h23;
        ta.loc[6] = 8'h12;
        ta.loc[7] = 8'h24;
        i_rac_host_model.step(ta);
        i_rac_host_model.snap();
        i_rac_host_model.step(mk(8'h46, 8'h00, 8'h00));
        for (int i = 0; i < 8; i++)
        begin
            i_rac_host_model.rd(8'(i), d);
            chk(d, ta.loc[i]);
        end
        $display("test snapshot done");
        i_rac_host_model.wr(8'h08, 8'h30);
        i_rac_host_model.wr(8'h09, 8'h12);
        i_rac_host_model.wr(8'h10, 8'h01);
        i_rac_host_model.step(mk(8'h29, 8'h00, 8'h00));
        settle();
        chk1(flag1, 1'b0);
        i_rac_host_model.step(mk(8'h30, 8'h00, 8'h00));
        settle();
        chk1(flag1, 1'b1);
        chk1(flag2, 1'b0);
        @(posedge clock);
        #1;
        chk1(irq_a_n, 1'b0);
        chk1(irq_b_n, 1'b1);
        i_rac_host_model.step(mk(8'h31, 8'h00, 8'h00));
        settle();
        chk1(flag1, 1'b1);
        i_rac_host_model.clr(2'h1);
        chk1(flag1, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            i_rac_host_model.step(mk(8'h30, 8'h00, 8'h00));
            settle();
            chk1(flag1, 1'(i == 0));
            i_rac_host_model.clr(2'h1);
        end
        i_rac_host_model.wr(8'h10, 8'h03);
        i_rac_host_model.step(mk(8'h31, 8'h00, 8'h00));
        i_rac_host_model.step(mk(8'h30, 8'h00, 8'h00));
        settle();
        chk1(flag1, 1'b0);
        i_rac_host_model.step(mk(8'h30, 8'h12, 8'h03));
        settle();
        chk1(flag1, 1'b1);
        i_rac_host_model.clr(2'h1);
        $display("test alarm_one done");
        cfg(1'b0, 6'h0D);
        i_rac_host_model.wr(8'h0F, 8'h05);
        i_rac_host_model.wr(8'h10, 8'h80);
        i_rac_host_model.step(mk(8'h00, 8'h00, 8'h04));
        i_rac_host_model.step(mk(8'h00, 8'h00, 8'h05));
        settle();
        chk1(flag2, 1'b1);
        chk1(flag1, 1'b0);
        @(posedge clock);
        #1;
        chk1(irq_a_n, 1'b0);
        // pin b went low one edge before this point, so that cycle counts already
        n = 1;
        while (irq_b_n === 1'b0 && n < 300)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(8'(n), 8'(rac_pkg::IRQ_PULSE_CYCLES));
        chk1(irq_a_n, 1'b0);
        i_rac_host_model.clr(2'h3);
        $display("test alarm_two done");
        cfg(1'b1, 6'h32);
        i_rac_host_model.wr(8'h0C, 8'h12);
        i_rac_host_model.wr(8'h10, 8'h10);
        i_rac_host_model.step(mk(8'h00, 8'h00, 8'h11));
        settle();
        chk1(flag1, 1'b0);
        i_rac_host_model.step(mk(8'h00, 8'h00, 8'h12));
        settle();
        chk1(flag1, 1'b1);
        @(posedge clock);
        #1;
        chk1(irq_b_n, 1'b0);
        chk1(irq_a_n, 1'b0);
        $display("test elapsed_mode done");
        stop_test();
    end
endmodule

`default_nettype wire
